// ==== core/sdc_top.sv ====
// converter control top: AXI4-Lite registers, pacing and interrupt
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module sdc_top (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// write address channel
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic [2:0]              s_axi_awprot,
	// write data channel
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	// write response channel
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	output logic [1:0]                   s_axi_bresp,
	// read address channel
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic [2:0]              s_axi_arprot,
	// read data channel
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	// conversion side
	input  wire logic                    conv_tick,
	output logic                         conv_run,
	output sdc_pkg::sdc_pair_t           play_pair,
	output logic                         play_strobe,
	output logic                         sample_request_flag,
	output logic                         irq
);
	import sdc_pkg::*;

	// ----------------------------------------------------------------
	// write channel capture
	// ----------------------------------------------------------------
	logic                  aw_held;
	logic [SDC_ADDR_W-1:0] aw_addr;
	logic                  w_held;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;

	// either channel may arrive first; each is held until both are in
	wire do_write = aw_held && w_held && !s_axi_bvalid;

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= SDC_RESET_WORD;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	wire [5:0] w_index = aw_addr[7:2];
	wire hit_w_sample  = (w_index == SDC_OFF_SAMPLE[7:2]);
	wire hit_w_control = (w_index == SDC_OFF_CONTROL[7:2]);
	wire hit_w_mstate  = (w_index == SDC_OFF_MASK_STATE[7:2]);
	wire hit_w_mset    = (w_index == SDC_OFF_MASK_SET[7:2]);
	wire hit_w_mclear  = (w_index == SDC_OFF_MASK_CLEAR[7:2]);
	wire hit_w_fclear  = (w_index == SDC_OFF_FLAG_CLEAR[7:2]);
	wire hit_w_fstate  = (w_index == SDC_OFF_FLAG_STATE[7:2]);
	wire w_mapped      = hit_w_sample | hit_w_control | hit_w_mstate |
	                     hit_w_mset | hit_w_mclear | hit_w_fclear |
	                     hit_w_fstate;

	// byte strobes widened to a bit mask
	wire [31:0] w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
	                      {8{w_strb[1]}}, {8{w_strb[0]}}};
	// only the lanes that were written may carry a one into a strobe reg
	wire [31:0] w_ones = w_data & w_mask;

	// ----------------------------------------------------------------
	// control word
	// ----------------------------------------------------------------
	logic [31:0] control_word;
	wire         ctrl_on   = control_word[SDC_CTRL_ON_BIT];
	wire         ctrl_xchg = control_word[SDC_CTRL_XCHG_BIT];
	wire [31:0]  next_control_word =
		((control_word & ~w_mask) | w_ones) & SDC_CTRL_WRITABLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_word <= SDC_RESET_WORD;
		end else if (do_write && hit_w_control) begin
			control_word <= next_control_word;
		end
	end

	assign conv_run = ctrl_on;

	// ----------------------------------------------------------------
	// sample word
	// ----------------------------------------------------------------
	// with exchange on, data and lane strobes trade halves together so a
	// partial write still lands in the intended channel field
	wire [31:0] s_data = ctrl_xchg ? {w_data[15:0], w_data[31:16]}
	                               : w_data;
	wire [31:0] s_mask = ctrl_xchg ? {w_mask[15:0], w_mask[31:16]}
	                               : w_mask;
	sdc_pair_t  sample_word;
	sdc_pair_t  next_sample_word;
	wire        sample_load = do_write && hit_w_sample;

	// channel 0 in the low halfword, channel 1 in the high one
	assign next_sample_word = sdc_pair_t'((sample_word & ~s_mask) |
	                                      (s_data & s_mask));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sample_word <= '0;
		end else if (sample_load) begin
			sample_word <= next_sample_word;
		end
	end

	// ----------------------------------------------------------------
	// pacing of samples toward the modulator
	// ----------------------------------------------------------------
	logic ready_level;
	logic underrun_pulse;

	sdc_pacer u_pacer (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.run         (ctrl_on),
		.conv_tick   (conv_tick),
		.load        (sample_load),
		.load_pair   (next_sample_word),
		.ready       (ready_level),
		.underrun    (underrun_pulse),
		.play_pair   (play_pair),
		.play_strobe (play_strobe)
	);

	assign sample_request_flag = ready_level;

	// ----------------------------------------------------------------
	// interrupt registers
	// ----------------------------------------------------------------
	wire [1:0] write_bits = {w_ones[SDC_IRQ_READY_BIT],
	                         w_ones[SDC_IRQ_UNDER_BIT]};
	wire [1:0] mask_set_bits   = (do_write && hit_w_mset)   ? write_bits
	                                                        : 2'h0;
	wire [1:0] mask_clear_bits = (do_write && hit_w_mclear) ? write_bits
	                                                        : 2'h0;
	wire [1:0] flag_clear_bits = (do_write && hit_w_fclear) ? write_bits
	                                                        : 2'h0;
	wire [1:0] event_bits;
	logic      status_read;
	logic [1:0] irq_mask_state;
	logic [1:0] irq_flag_state;

	assign event_bits[SDC_IDX_UNDER] = underrun_pulse;
	assign event_bits[SDC_IDX_READY] = ready_level;

	sdc_irq_unit u_irq (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.event_in   (event_bits),
		.mask_set   (mask_set_bits),
		.mask_clear (mask_clear_bits),
		.flag_clear (flag_clear_bits),
		.read_clear (status_read),
		.mask       (irq_mask_state),
		.status     (irq_flag_state),
		.irq        (irq)
	);

	// ----------------------------------------------------------------
	// write response
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= SDC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= w_mapped ? SDC_RESP_OKAY : SDC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	wire [5:0] r_index = s_axi_araddr[7:2];
	wire hit_r_sample  = (r_index == SDC_OFF_SAMPLE[7:2]);
	wire hit_r_control = (r_index == SDC_OFF_CONTROL[7:2]);
	wire hit_r_mstate  = (r_index == SDC_OFF_MASK_STATE[7:2]);
	wire hit_r_wonly   = (r_index == SDC_OFF_MASK_SET[7:2]) |
	                     (r_index == SDC_OFF_MASK_CLEAR[7:2]) |
	                     (r_index == SDC_OFF_FLAG_CLEAR[7:2]);
	wire hit_r_fstate  = (r_index == SDC_OFF_FLAG_STATE[7:2]);
	wire r_mapped      = hit_r_sample | hit_r_control | hit_r_mstate |
	                     hit_r_wonly | hit_r_fstate;
	wire r_take        = s_axi_arvalid && s_axi_arready;

	// both flag views share one layout
	wire [31:0] mask_view = {2'h0, irq_mask_state[SDC_IDX_READY],
	                         irq_mask_state[SDC_IDX_UNDER], 28'h0};
	wire [31:0] flag_view = {2'h0, irq_flag_state[SDC_IDX_READY],
	                         irq_flag_state[SDC_IDX_UNDER], 28'h0};

	// write-only and unmapped words read as zero
	wire [31:0] read_mux =
		hit_r_sample  ? 32'(sample_word) :
		hit_r_control ? control_word :
		hit_r_mstate  ? mask_view :
		hit_r_fstate  ? flag_view : 32'h0000_0000;

	assign s_axi_arready = !s_axi_rvalid;
	assign status_read   = r_take && hit_r_fstate;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= SDC_RESET_WORD;
			s_axi_rresp  <= SDC_RESP_OKAY;
		end else if (r_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= read_mux;
			s_axi_rresp  <= r_mapped ? SDC_RESP_OKAY : SDC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// protection bits carry nothing for this block
	wire unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule : sdc_top

// ==== core/sdc_pkg.sv ====
// constants, types and register map of the sigma-delta converter control
// Notes on behaviour
// - control_word bit 31 turns the converter on; zero disables it.
// - control_word bit 30 enables exchange of the two channel samples.
// - irq_mask_state bit 29 enables ready interrupt, bit 28 underrun.
// - a one written to irq_mask_set sets that mask bit.
// - a one written to irq_mask_clear clears that mask bit.
// - zeros written to mask-set, mask-clear or flag-clear change nothing.
// - a one written to irq_flag_clear clears the underrun flag and its request.
// - the ready flag is high exactly while a new sample word fits.
// - the underrun flag stays set until reset, an explicit clear or a read of irq_flag_state.
// - sample_word: channel 0 in low halfword, channel 1 in high halfword.
// - reading irq_flag_state also clears its underrun flag.
// - with exchange on, written halfwords land in the other channel field.
package sdc_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int              SDC_ADDR_W         = 8;
	localparam logic [7:0]      SDC_OFF_SAMPLE     = 8'h00;
	localparam logic [7:0]      SDC_OFF_CONTROL    = 8'h08;
	localparam logic [7:0]      SDC_OFF_MASK_STATE = 8'h0C;
	localparam logic [7:0]      SDC_OFF_MASK_SET   = 8'h10;
	localparam logic [7:0]      SDC_OFF_MASK_CLEAR = 8'h14;
	localparam logic [7:0]      SDC_OFF_FLAG_CLEAR = 8'h18;
	localparam logic [7:0]      SDC_OFF_FLAG_STATE = 8'h1C;
	localparam logic [31:0]     SDC_RESET_WORD     = 32'h0000_0000;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int              SDC_CTRL_ON_BIT    = 31;
	localparam int              SDC_CTRL_XCHG_BIT  = 30;
	localparam int              SDC_IRQ_READY_BIT  = 29;
	localparam int              SDC_IRQ_UNDER_BIT  = 28;
	localparam logic [31:0]     SDC_CTRL_WRITABLE  = 32'hC000_0000;
	// index of each flag inside the two-bit flag vectors
	localparam int              SDC_IDX_UNDER      = 0;
	localparam int              SDC_IDX_READY      = 1;
	localparam logic [1:0]      SDC_FLAG_STICKY    = 2'h1;
	// ----------------------------------------------------------------
	// timing and bus answers
	// ----------------------------------------------------------------
	localparam int              SDC_CONV_PER_SAMPLE = 256;
	localparam logic [7:0]      SDC_CONV_LAST      = 8'(SDC_CONV_PER_SAMPLE - 1);
	localparam logic [1:0]      SDC_RESP_OKAY      = 2'h0;
	localparam logic [1:0]      SDC_RESP_SLVERR    = 2'h2;

	typedef struct packed {
		logic [15:0] upper_half_sample;
		logic [15:0] lower_half_sample;
	} sdc_pair_t;

	typedef enum logic [0:0] {
		SDC_PACE_IDLE = 1'b0,
		SDC_PACE_RUN  = 1'b1
	} sdc_pace_t;
endpackage : sdc_pkg

// ==== core/sdc_pacer.sv ====
// sample pacing: holding word, conversion tick counter, underrun detection
`timescale 1ns/1ps
module sdc_pacer (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              run,
	input  wire logic              conv_tick,
	input  wire logic              load,
	input  wire sdc_pkg::sdc_pair_t load_pair,
	output logic                   ready,
	output logic                   underrun,
	output sdc_pkg::sdc_pair_t     play_pair,
	output logic                   play_strobe
);
	import sdc_pkg::*;

	sdc_pace_t  state;
	logic [7:0] count;
	logic       held;
	sdc_pair_t  hold_pair;
	wire        period_end = conv_tick && (count == SDC_CONV_LAST);

	// ----------------------------------------------------------------
	// pacing
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state       <= SDC_PACE_IDLE;
			count       <= 8'h00;
			held        <= 1'b0;
			hold_pair   <= '0;
			play_pair   <= '0;
			play_strobe <= 1'b0;
			underrun    <= 1'b0;
		end else begin
			play_strobe <= 1'b0;
			underrun    <= 1'b0;
			if (load) begin
				hold_pair <= load_pair;
				held      <= 1'b1;
			end
			unique case (state)
				SDC_PACE_IDLE: begin
					count <= 8'h00;
					if (run) begin
						state <= SDC_PACE_RUN;
					end
				end
				SDC_PACE_RUN: begin
					if (!run) begin
						state <= SDC_PACE_IDLE;
					end else if (conv_tick) begin
						count <= count + 8'h01;
						if (period_end) begin
							if (held || load) begin
								play_pair   <= load ? load_pair : hold_pair;
								held        <= 1'b0;
								play_strobe <= 1'b1;
							end else begin
								underrun <= 1'b1;
							end
						end
					end
				end
			endcase
		end
	end

	// a word fits while enabled and nothing waits in the holding word;
	// taken from run itself so the flag follows the on bit without lag
	assign ready = run && !held;
endmodule : sdc_pacer

// ==== core/sdc_irq_unit.sv ====
// interrupt flags, mask and request line
`timescale 1ns/1ps
module sdc_irq_unit (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [1:0] event_in,
	input  wire logic [1:0] mask_set,
	input  wire logic [1:0] mask_clear,
	input  wire logic [1:0] flag_clear,
	input  wire logic       read_clear,
	output logic      [1:0] mask,
	output logic      [1:0] status,
	output logic            irq
);
	import sdc_pkg::*;

	// ----------------------------------------------------------------
	// one mask bit and one flag per interrupt source
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_src
		logic sticky;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				mask[i] <= 1'b0;
				sticky  <= 1'b0;
			end else begin
				if (mask_set[i]) begin
					mask[i] <= 1'b1;
				end else if (mask_clear[i]) begin
					mask[i] <= 1'b0;
				end
				// set wins so an event in the clearing cycle survives
				if (event_in[i]) begin
					sticky <= 1'b1;
				end else if (flag_clear[i] || read_clear) begin
					sticky <= 1'b0;
				end
			end
		end
		// a level flag follows its source; a clear does not change it
		assign status[i] = SDC_FLAG_STICKY[i] ? sticky : event_in[i];
	end

	assign irq = |(status & mask);
endmodule : sdc_irq_unit

// ==== tb/sdc_props.sv ====
// assertion checker on the converter control top ports
`timescale 1ns/1ps
module sdc_props
	import sdc_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        conv_tick,
	input wire logic        conv_run,
	input wire logic        play_strobe,
	input wire logic        sample_request_flag
);
	// ----------------------------------------------------------------
	// last write address and data, valid once bvalid rises
	// ----------------------------------------------------------------
	logic [7:0]  wa;
	logic [31:0] wd;
	wire         mapped = (wa[7:5] == 3'h0) && (wa[4:2] != 3'h1);
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_run_set; $rose(s_axi_bvalid) && wa == 8'h08 |-> conv_run == wd[31]; endproperty
	a_run_set: assert property (p_run_set) else $error("run bit not applied");
	property p_ready_run; sample_request_flag |-> conv_run; endproperty
	a_ready_run: assert property (p_ready_run) else $error("ready while off");
	property p_ready_drop; $rose(s_axi_bvalid) && wa == 8'h00 && !play_strobe |-> !sample_request_flag; endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready after load");
	property p_strobe_tick; play_strobe |-> $past(conv_tick) && $past(conv_run); endproperty
	a_strobe_tick: assert property (p_strobe_tick) else $error("stray strobe");
	property p_strobe_pulse; play_strobe |=> !play_strobe; endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("long strobe");
	property p_bresp; $rose(s_axi_bvalid) |-> s_axi_bresp == (mapped ? SDC_RESP_OKAY : SDC_RESP_SLVERR); endproperty
	a_bresp: assert property (p_bresp) else $error("wrong bresp");
	property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
	a_b_lat: assert property (p_b_lat) else $error("no write answer");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_lat: assert property (p_r_lat) else $error("no read answer");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && !s_axi_arready; endproperty
	a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
endmodule : sdc_props

// ==== tb/sdc_host.sv ====
// bus master and conversion tick source facing the block
`timescale 1ns/1ps
module sdc_host (
	input wire logic         aclk,
	output logic             s_axi_awvalid,
	input wire logic         s_axi_awready,
	output logic [7:0]       s_axi_awaddr,
	output logic [2:0]       s_axi_awprot,
	output logic             s_axi_wvalid,
	input wire logic         s_axi_wready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	input wire logic         s_axi_bvalid,
	output logic             s_axi_bready,
	input wire logic [1:0]   s_axi_bresp,
	output logic             s_axi_arvalid,
	input wire logic         s_axi_arready,
	output logic [7:0]       s_axi_araddr,
	output logic [2:0]       s_axi_arprot,
	input wire logic         s_axi_rvalid,
	output logic             s_axi_rready,
	input wire logic [31:0]  s_axi_rdata,
	input wire logic [1:0]   s_axi_rresp,
	output logic             conv_tick
);
	assign s_axi_awprot = 3'h0;
	assign s_axi_arprot = 3'h0;
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, conv_tick} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0;
		s_axi_wdata = 32'h0;
	end
	// ----------------------------------------------------------------
	// one word write, address and data offered together
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'hF;
		s_axi_bready  <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// n ticks; software stalls past a period only when told to
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge aclk);
			conv_tick <= 1'b1;
		end
		@(posedge aclk);
		conv_tick <= 1'b0;
	endtask : tick
endmodule : sdc_host

// ==== tb/tb_top.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
	import sdc_pkg::*;
	logic        aclk, aresetn, conv_tick, conv_run, play_strobe, irq;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, sample_request_flag;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	sdc_pair_t   play_pair;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	sdc_top  sdc_top_i (.*);
	sdc_host sdc_host_i (.*);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		sdc_host_i.rd(a, rd_d, rsp);
		chk("rdata", e, rd_d);
		chk("rresp", {30'h0, SDC_RESP_OKAY}, {30'h0, rsp});
	endtask : rd_chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		sdc_host_i.wr(a, d, rsp);
		chk("bresp", {30'h0, SDC_RESP_OKAY}, {30'h0, rsp});
	endtask : wr
	task automatic settle();
		repeat (2) @(posedge aclk);
	endtask : settle
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_map();
		rd_chk(SDC_OFF_CONTROL, 32'h0);
		rd_chk(SDC_OFF_MASK_STATE, 32'h0);
		rd_chk(SDC_OFF_MASK_SET, 32'h0);
		sdc_host_i.rd(8'h04, rd_d, rsp);
		chk("rresp", 32'h2, {30'h0, rsp});
		chk("rdata", 32'h0, rd_d);
		sdc_host_i.wr(8'h20, 32'hFFFF_FFFF, rsp);
		chk("bresp", 32'h2, {30'h0, rsp});
		wr(SDC_OFF_FLAG_STATE, 32'hFFFF_FFFF);
		rd_chk(SDC_OFF_FLAG_STATE, 32'h0);
	endtask : t_reset_map
	task automatic t_mask();
		wr(SDC_OFF_MASK_SET, 32'h3000_0000);
		rd_chk(SDC_OFF_MASK_STATE, 32'h3000_0000);
		wr(SDC_OFF_MASK_SET, 32'h0);
		wr(SDC_OFF_MASK_CLEAR, 32'h0);
		rd_chk(SDC_OFF_MASK_STATE, 32'h3000_0000);
		wr(SDC_OFF_MASK_CLEAR, 32'h2000_0000);
		rd_chk(SDC_OFF_MASK_STATE, 32'h1000_0000);
		chk("irq", 32'h0, {31'h0, irq});
		wr(SDC_OFF_MASK_CLEAR, 32'h1000_0000);
	endtask : t_mask
	task automatic t_ready_irq();
		wr(SDC_OFF_CONTROL, 32'h8000_0000);
		chk("run", 32'h1, {31'h0, conv_run});
		chk("ready", 32'h1, {31'h0, sample_request_flag});
		rd_chk(SDC_OFF_FLAG_STATE, 32'h2000_0000);
		wr(SDC_OFF_MASK_SET, 32'h2000_0000);
		chk("irq", 32'h1, {31'h0, irq});
		wr(SDC_OFF_SAMPLE, 32'h1234_5678);
		chk("ready", 32'h0, {31'h0, sample_request_flag});
		chk("irq", 32'h0, {31'h0, irq});
		wr(SDC_OFF_MASK_CLEAR, 32'h2000_0000);
	endtask : t_ready_irq
	task automatic t_play_swap();
		sdc_host_i.tick(256);
		settle();
		chk("pair", 32'h1234_5678, play_pair);
		chk("ready", 32'h1, {31'h0, sample_request_flag});
		wr(SDC_OFF_CONTROL, 32'hC000_0000);
		wr(SDC_OFF_SAMPLE, 32'h1234_5678);
		rd_chk(SDC_OFF_SAMPLE, 32'h5678_1234);
		sdc_host_i.tick(256);
		settle();
		chk("pair", 32'h5678_1234, play_pair);
	endtask : t_play_swap
	task automatic t_underrun();
		sdc_host_i.tick(256);
		settle();
		rd_chk(SDC_OFF_FLAG_STATE, 32'h3000_0000);
		rd_chk(SDC_OFF_FLAG_STATE, 32'h2000_0000);
		sdc_host_i.tick(512);
		wr(SDC_OFF_MASK_SET, 32'h1000_0000);
		repeat (20) @(posedge aclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(SDC_OFF_FLAG_CLEAR, 32'h0);
		chk("irq", 32'h1, {31'h0, irq});
		wr(SDC_OFF_FLAG_CLEAR, 32'h1000_0000);
		chk("irq", 32'h0, {31'h0, irq});
		rd_chk(SDC_OFF_FLAG_STATE, 32'h2000_0000);
	endtask : t_underrun
	task automatic t_disable();
		wr(SDC_OFF_CONTROL, 32'h0);
		chk("run", 32'h0, {31'h0, conv_run});
		chk("ready", 32'h0, {31'h0, sample_request_flag});
		sdc_host_i.tick(256);
		settle();
		chk("irq", 32'h0, {31'h0, irq});
		rd_chk(SDC_OFF_FLAG_STATE, 32'h0);
	endtask : t_disable
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// watchdog sized for about 1500 ticks plus bus traffic
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count = err_count + 1;
			tally_and_finish();
		end
	end
	initial begin
		aresetn = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_map();
		t_mask();
		t_ready_irq();
		t_play_swap();
		t_underrun();
		t_disable();
		tally_and_finish();
	end
endmodule : tb_top
bind sdc_top sdc_props sdc_props_i (.*);
